// [src/cmp_ctrl_defs.svh]
// Register offsets, field positions, reset values and mode codes.
`ifndef CMP_CTRL_DEFS_SVH
`define CMP_CTRL_DEFS_SVH
`define OFS_IMC 8'h0B
`define OFS_PFB2 8'h0D
`define OFS_PAD 8'h85
`define OFS_PEB2 8'h8D
`define OFS_CC 8'h9C
`define OFS_RLC 8'h9D
`define OFS_PAIN 8'hA0
`define OFS_PORTA 8'h05
`define RST_CC 8'h07
`define RST_PAD 8'hFF
`define RST_RLC 8'h00
`define RLC_MASK 8'hEF
`define BIT_GIE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_CMF 6
`define BIT_COMPARATOR_CHANGE_ENABLE 6
`define BIT_CMP_TWO_RESULT 7
`define BIT_CMP_ONE_RESULT 6
`define BIT_CMP_TWO_INVERT 5
`define BIT_CMP_ONE_INVERT 4
`define BIT_CIS 3
`define MODE_ONE_SW 3'h1
`define MODE_INTREF 3'h2
`define MODE_OFF 3'h7
`endif

// [src/cmp_ctrl_pkg.sv]
// Types shared by the comparator control logic.
package cmp_ctrl_pkg;
   typedef struct packed {
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [7:0] addr;
   } ahb_req_s;
   typedef struct packed {
      logic input_switch_select;
      logic [2:0] mode;
      logic intref;
   } route_s;
endpackage : cmp_ctrl_pkg

// [src/dual_comparator_control_irq.sv]
// Control and status logic around two analog voltage comparators.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
module dual_comparator_control_irq
   import cmp_ctrl_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic CMP_ONE_RAW_I,
   input wire logic CMP_TWO_RAW_I,
   input wire logic [7:0] PORT_A_PIN_I,
   input wire logic [7:0] PORT_A_DATA_OUT_I,
   input wire logic SLEEP_I,
   output logic [7:0] PORT_A_PIN_O,
   output logic [7:0] PORT_A_PIN_OE_O,
   output logic [2:0] COMPARATOR_MODE_O,
   output logic INPUT_SWITCH_SELECT_O,
   output logic INTREF_TO_POSITIVE_O,
   output logic [7:0] REFERENCE_LADDER_O,
   output logic IRQ_O,
   output logic WAKE_O
);

   ahb_req_s req_r;
   logic dphase_r;
   logic [7:0] cc_r;
   logic [7:0] pad_r;
   logic [7:0] rlc_r;
   logic [7:0] pain_r;
   logic gie_r, peripheral_irq_enable_r, comparator_change_enable_r, flag_r;
   logic [2:0] s1_r, s2_r;
   logic [1:0] sy1_r, sy2_r, sy3_r, res_filt_r;
   logic rd_done_r;
   logic [1:0] latched_r;
   logic [7:0] pa1_r, pa2_r, pa3_r, pa_r;
   logic addr_ok;
   logic wr_acc, rd_acc, cc_acc;
   logic [7:0] wdat;
   logic [1:0] live_res, res_sync;
   logic mismatch;
   logic [7:0] rdat;
   logic pins_out;
   route_s route;

   // Polarity applied to raw comparator outputs on the live path, and after the synchronisers on the register path.
   assign live_res = {CMP_TWO_RAW_I ^ cc_r[`BIT_CMP_TWO_INVERT],
                      CMP_ONE_RAW_I ^ cc_r[`BIT_CMP_ONE_INVERT]};
   assign res_sync = res_filt_r ^ {cc_r[`BIT_CMP_TWO_INVERT], cc_r[`BIT_CMP_ONE_INVERT]};

   assign addr_ok = 1'b1;
   assign wdat = HWDATA_I[7:0];
   assign wr_acc = dphase_r & req_r.hwrite;
   assign rd_acc = dphase_r & ~req_r.hwrite;
   assign cc_acc = dphase_r & (req_r.addr == `OFS_CC);

   // Bus address phase capture; reads take one wait state for the data.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         dphase_r <= 1'b0;
         req_r <= '0;
      end else if (HREADY_I) begin
         dphase_r <= HSEL_I & HTRANS_I[1] & addr_ok;
         req_r.htrans <= HTRANS_I;
         req_r.hwrite <= HWRITE_I;
         req_r.hsize <= HSIZE_I;
         req_r.addr <= HADDR_I[9:2];
      end
   end
   // Read data is registered, so the first data cycle of a read waits.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rd_done_r <= 1'b0;
      end else begin
         rd_done_r <= rd_acc & ~rd_done_r;
      end
   end
   assign HREADYOUT_O = ~(rd_acc & ~rd_done_r);
   assign HRESP_O = 1'b0;

   // Control register; untouched by sleep, only reset restores it.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cc_r <= `RST_CC;
      end else if (wr_acc && req_r.addr == `OFS_CC) begin
         cc_r[5:0] <= wdat[5:0];
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pad_r <= `RST_PAD;
         rlc_r <= `RST_RLC;
         pain_r <= 8'hFF;
         gie_r <= 1'b0;
         peripheral_irq_enable_r <= 1'b0;
         comparator_change_enable_r <= 1'b0;
      end else if (wr_acc) begin
         case (req_r.addr)
            `OFS_PAD: pad_r <= wdat;
            `OFS_RLC: rlc_r <= wdat & `RLC_MASK;
            `OFS_PAIN: pain_r <= wdat;
            `OFS_IMC: begin
               gie_r <= wdat[`BIT_GIE];
               peripheral_irq_enable_r <= wdat[`BIT_PERIPHERAL_IRQ_ENABLE];
            end
            `OFS_PEB2: comparator_change_enable_r <= wdat[`BIT_COMPARATOR_CHANGE_ENABLE];
            default: ;
         endcase
      end
   end

   // Three-stage synchronisers for results and port pins.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sy1_r <= '0;
         sy2_r <= '0;
         sy3_r <= '0;
         res_filt_r <= '0;
         pa1_r <= '0;
         pa2_r <= '0;
         pa3_r <= '0;
         pa_r <= '0;
      end else begin
         sy1_r <= {CMP_TWO_RAW_I, CMP_ONE_RAW_I};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         for (int j = 0; j < 2; j++) begin
            if (sy2_r[j] == sy3_r[j]) begin
               res_filt_r[j] <= sy3_r[j];
            end
         end
         pa1_r <= PORT_A_PIN_I;
         pa2_r <= pa1_r;
         pa3_r <= pa2_r;
         for (int i = 0; i < 8; i++) begin
            if (pa2_r[i] == pa3_r[i]) begin
               pa_r[i] <= pa3_r[i];
            end
         end
      end
   end

   // Latched copy refreshed by any control register access.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         latched_r <= '0;
      end else if (cc_acc) begin
         latched_r <= res_sync;
      end
   end
   // An access in the same cycle as a change may swallow it.
   assign mismatch = (res_sync != latched_r) & ~cc_acc;

   // Flag: hardware set wins over software clear.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         flag_r <= 1'b0;
      end else if (mismatch) begin
         flag_r <= 1'b1;
      end else if (wr_acc && req_r.addr == `OFS_PFB2) begin
         flag_r <= wdat[`BIT_CMF];
      end
   end

   assign IRQ_O = flag_r & comparator_change_enable_r & peripheral_irq_enable_r & gie_r;
   // Wake path compares live results with the latch, needing no clock.
   assign WAKE_O = SLEEP_I & comparator_change_enable_r & peripheral_irq_enable_r
                 & ((live_res != latched_r) | flag_r);

   // Mode 111 leaves both comparators off; user is advised to pick it.
   assign COMPARATOR_MODE_O = cc_r[2:0];
   assign route.input_switch_select = cc_r[`BIT_CIS];
   assign route.mode = cc_r[2:0];
   assign route.intref = (cc_r[2:0] == `MODE_INTREF);
   assign INTREF_TO_POSITIVE_O = route.intref;
   assign INPUT_SWITCH_SELECT_O = route.input_switch_select &
      ((route.mode == `MODE_ONE_SW) | route.intref);
   assign REFERENCE_LADDER_O = rlc_r;

   // Modes 011 and 110 enable result output on pins three and four.
   assign pins_out = (cc_r[2:0] == 3'h3) | (cc_r[2:0] == 3'h6);
   always_comb begin
      PORT_A_PIN_O = PORT_A_DATA_OUT_I;
      if (pins_out) begin
         PORT_A_PIN_O[3] = live_res[0];
         PORT_A_PIN_O[4] = live_res[1];
      end
   end
   assign PORT_A_PIN_OE_O = ~pad_r;

   always_comb begin
      rdat = 8'h00;
      case (req_r.addr)
         `OFS_CC: rdat = {res_sync, cc_r[5:0]};
         `OFS_PAD: rdat = pad_r;
         `OFS_RLC: rdat = rlc_r;
         `OFS_PAIN: rdat = pain_r;
         `OFS_IMC: rdat = {gie_r, peripheral_irq_enable_r, 6'h00};
         `OFS_PFB2: rdat = {1'b0, flag_r, 6'h00};
         `OFS_PEB2: rdat = {1'b0, comparator_change_enable_r, 6'h00};
         `OFS_PORTA: rdat = pa_r & ~pain_r;
         default: rdat = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         HRDATA_O <= '0;
      end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
         HRDATA_O <= '0;
      end else if (rd_acc && !rd_done_r) begin
         HRDATA_O <= {24'h00_0000, rdat};
      end
   end

endmodule : dual_comparator_control_irq

// [tb/dual_comparator_control_irq_props.sv]
// Port checker for the comparator control block.
`timescale 1ns/1ps
module dual_comparator_control_irq_props import cmp_ctrl_pkg::*; (
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic HSEL_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic CMP_ONE_RAW_I,
   input wire logic SLEEP_I,
   input wire logic [7:0] PORT_A_DATA_OUT_I,
   input wire logic [7:0] PORT_A_PIN_O,
   input wire logic [7:0] PORT_A_PIN_OE_O,
   input wire logic [2:0] COMPARATOR_MODE_O,
   input wire logic INTREF_TO_POSITIVE_O,
   input wire logic IRQ_O,
   input wire logic WAKE_O
);
   default clocking dc @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   logic wr_q;
   logic pin_m;
   assign wr_q = HSEL_I & HTRANS_I[1] & HWRITE_I;
   assign pin_m = COMPARATOR_MODE_O inside {3'h3, 3'h6};
   a_intref_mode: assert property (
      INTREF_TO_POSITIVE_O == (COMPARATOR_MODE_O == 3'h2))
      else $error("bad routing");
   a_pin_passthru: assert property (
      !pin_m |-> PORT_A_PIN_O == PORT_A_DATA_OUT_I) else $error("bad mux");
   a_pin_follows: assert property (
      pin_m && $stable(COMPARATOR_MODE_O) && $changed(CMP_ONE_RAW_I)
      |-> $changed(PORT_A_PIN_O[3])) else $error("pin not live");
   a_oe_by_write: assert property (
      $changed(PORT_A_PIN_OE_O) |-> $past(wr_q, 2)) else $error("oe moved");
   a_mode_by_write: assert property (
      $changed(COMPARATOR_MODE_O) |-> $past(wr_q, 2)) else $error("mode moved");
   a_reset_state: assert property (
      $rose(NRST_I) |-> COMPARATOR_MODE_O == 3'h7 && PORT_A_PIN_OE_O == 8'h00)
      else $error("bad reset state");
   a_irq_cleared: assert property (
      $fell(IRQ_O) |-> $past(wr_q, 2)) else $error("irq fell");
   a_wake_sleep: assert property (
      WAKE_O |-> SLEEP_I) else $error("wake when awake");
   c_irq: cover property ($rose(IRQ_O));
   c_wake: cover property ($rose(WAKE_O));
   c_pins: cover property (pin_m);
endmodule : dual_comparator_control_irq_props
bind dual_comparator_control_irq dual_comparator_control_irq_props
   dual_comparator_control_irq_props_inst (.CLK_SYS_I, .NRST_I, .HSEL_I,
   .HTRANS_I, .HWRITE_I, .CMP_ONE_RAW_I, .SLEEP_I, .PORT_A_DATA_OUT_I,
   .PORT_A_PIN_O, .PORT_A_PIN_OE_O, .COMPARATOR_MODE_O,
   .INTREF_TO_POSITIVE_O, .IRQ_O, .WAKE_O);

// [tb/dual_comparator_control_irq_tb.sv]
// Bench for the comparator control block.
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
module dual_comparator_control_irq_tb import cmp_ctrl_pkg::*; ;
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hw = 1'b0;
   logic c1 = 1'b0, c2 = 1'b0, slp = 1'b0, rdy, resp, sw, iref, irq, wake;
   logic [1:0] ht = 2'h0;
   logic [31:0] ha = 32'h0000_0000, wd = 32'h0000_0000, rdat;
   logic [7:0] pin = 8'hFF, dout = 8'hA5, po, oe, lad;
   logic [2:0] mode;
   int err_total = 0, check_count = 0;
   always #4 clk = ~clk;
   dual_comparator_control_irq dual_comparator_control_irq_inst (
      .CLK_SYS_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(ha),
      .HTRANS_I(ht), .HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(wd),
      .HREADY_I(rdy), .HRDATA_O(rdat), .HREADYOUT_O(rdy), .HRESP_O(resp),
      .CMP_ONE_RAW_I(c1), .CMP_TWO_RAW_I(c2), .PORT_A_PIN_I(pin),
      .PORT_A_DATA_OUT_I(dout), .SLEEP_I(slp), .PORT_A_PIN_O(po),
      .PORT_A_PIN_OE_O(oe), .COMPARATOR_MODE_O(mode),
      .INPUT_SWITCH_SELECT_O(sw), .INTREF_TO_POSITIVE_O(iref),
      .REFERENCE_LADDER_O(lad), .IRQ_O(irq), .WAKE_O(wake));
   task automatic final_report;
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic acc(logic w, logic [7:0] i, logic [7:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      ht <= 2'h2;
      hw <= w;
      ha <= {22'h00_0000, i, 2'h0};
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      ht <= 2'h0;
      hsel <= 1'b0;
      wd <= {24'h00_0000, d};
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
   endtask : acc
   task automatic wr(logic [7:0] i, logic [7:0] d);
      acc(1'b1, i, d);
   endtask : wr
   // Read data is taken at the edge that ends the data phase.
   task automatic rd(logic [7:0] i, logic [7:0] e);
      acc(1'b0, i, 8'h00);
      chk($sformatf("reg %h", i), {24'h00_0000, e}, rdat);
   endtask : rd
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask : settle
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd(`OFS_CC, 8'h07);
      rd(`OFS_PAD, 8'hFF);
      rd(`OFS_RLC, 8'h00);
      rd(8'hFF, 8'h00);
      wr(`OFS_CC, 8'hCA);
      rd(`OFS_CC, 8'h0A);
      chk("intref", 1'b1, iref);
      chk("switch", 1'b1, sw);
      @(posedge clk) c1 <= 1'b1;
      settle();
      for (int k = 0; k < 4; k++) begin
         wr(`OFS_CC, {2'h0, k[1:0], 4'h2});
         rd(`OFS_CC, {k[1], ~k[0], k[1:0], 4'h2});
      end
      wr(`OFS_CC, 8'h03);
      #1 chk("pins", 2'b01, po[4:3]);
      @(posedge clk) c1 <= 1'b0;
      #1 chk("pins", 2'b00, po[4:3]);
      wr(`OFS_PAD, 8'hF7);
      #1 chk("oe", 8'h08, oe);
      rd(`OFS_PORTA, 8'h00);
      wr(`OFS_PAIN, 8'h0F);
      rd(`OFS_PORTA, 8'hF0);
      wr(`OFS_IMC, 8'hC0);
      wr(`OFS_PEB2, 8'h40);
      rd(`OFS_CC, 8'h03);
      wr(`OFS_PFB2, 8'h00);
      #1 chk("irq", 1'b0, irq);
      @(posedge clk) c2 <= 1'b1;
      settle();
      chk("irq", 1'b1, irq);
      wr(`OFS_PFB2, 8'h00);
      rd(`OFS_PFB2, 8'h40);
      rd(`OFS_CC, 8'h83);
      wr(`OFS_PFB2, 8'h00);
      rd(`OFS_PFB2, 8'h00);
      wr(`OFS_IMC, 8'h40);
      wr(`OFS_PFB2, 8'h40);
      #1 chk("irq", 1'b0, irq);
      rd(`OFS_PFB2, 8'h40);
      wr(`OFS_PFB2, 8'h00);
      @(posedge clk) slp <= 1'b1;
      #1 chk("wake", 1'b0, wake);
      @(posedge clk) c1 <= 1'b1;
      settle();
      chk("wake", 1'b1, wake);
      chk("mode", 3'h3, mode);
      @(posedge clk) slp <= 1'b0;
      c1 <= 1'b0;
      c2 <= 1'b0;
      settle();
      nrst <= 1'b0;
      @(posedge clk) nrst <= 1'b1;
      rd(`OFS_CC, 8'h07);
      chk("oe", 8'h00, oe);
      final_report();
   end
endmodule : dual_comparator_control_irq_tb
